// ### src/mds_pkg.sv
// Purpose: constants and carriers for the monitor display selector
// Assumes: one 100 MHz clock, plain register port
// Notes: codes are decimal monitor-select values held as hex
package mds_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned HOLD_TIME_MS  = 1000;
  localparam int unsigned BLINK_TIME_MS = 250;
  localparam int unsigned HOUR_S        = 3600;

  localparam logic [7:0] CODE_CYCLE   = 8'h00;
  localparam logic [7:0] CODE_LOAD    = 8'h11;
  localparam logic [7:0] CODE_EXC     = 8'h12;
  localparam logic [7:0] CODE_PPULSE  = 8'h13;
  localparam logic [7:0] CODE_ENERG   = 8'h14;
  localparam logic [7:0] CODE_ORIENT  = 8'h16;
  localparam logic [7:0] CODE_RUNTIME = 8'h17;
  localparam logic [7:0] CODE_LFACTOR = 8'h18;
  localparam logic [7:0] CODE_PID_SP  = 8'h34;
  localparam logic [7:0] CODE_PID_PV  = 8'h35;
  localparam logic [7:0] CODE_PID_DEV = 8'h36;
  localparam logic [7:0] CODE_TERM    = 8'h37;
  localparam logic [7:0] CODE_OPT_IN  = 8'h38;
  localparam logic [7:0] CODE_OPT_OUT = 8'h39;
  localparam logic [7:0] CODE_SEQ     = 8'h46;
  localparam logic [7:0] CODE_SETFREQ = 8'h64;

  localparam logic [3:0] REG_MON_SEL   = 4'h0;
  localparam logic [3:0] REG_PULSE_SRC = 4'h1;
  localparam logic [3:0] REG_VOLT_SRC  = 4'h2;
  localparam logic [3:0] REG_ENERG_HRS = 4'h3;
  localparam logic [3:0] REG_RUN_HRS   = 4'h4;
  localparam logic [3:0] REG_STATUS    = 4'h5;

  localparam logic [7:0]  MON_SEL_RST = 8'h00;
  localparam logic [7:0]  OUT_SRC_RST = 8'h46;
  localparam logic [15:0] HOURS_DIV   = 16'h000a;
  localparam logic [15:0] DASH_LIMIT  = 16'h270f;
  localparam logic [3:0]  DP_HOURS    = 4'h2;
  localparam logic [3:0]  DP_OPT_IN   = 4'h1;
  localparam logic [3:0]  DP_OPT_OUT  = 4'h2;
  localparam int unsigned SEG_CENTRE  = 6;
  localparam int unsigned SEG_DP      = 7;

  typedef enum logic [1:0] {
    POS_FREQ, POS_CURR, POS_VOLT, POS_FAULT
  } mds_pos_type;

  typedef enum logic [1:0] {
    KEY_IDLE, KEY_DOWN, KEY_HELD
  } mds_key_type;

  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] set_freq;
    logic [15:0] curr;
    logic [15:0] volt;
    logic [15:0] fault_code;
    logic [15:0] pid_sp;
    logic [15:0] pid_pv;
    logic [15:0] pid_dev;
    logic [15:0] load_meter;
    logic [15:0] exc_curr;
    logic [15:0] load_factor;
    logic [15:0] pos_pulse;
    logic [15:0] orient_stat;
    logic [15:0] seq_value;
    logic [15:0] tune_stat;
  } mds_drv_type;

  typedef struct packed {
    logic        running;
    logic        fault;
    logic        tuning;
    logic        orient_en;
  } mds_flag_type;

  typedef struct packed {
    logic [11:0] in_terms;
    logic [11:0] out_terms;
    logic [23:0] opt_in;
    logic [23:0] opt_out;
    logic        opt_in_fit;
    logic        opt_out_fit;
  } mds_term_type;

  typedef struct packed {
    logic        seg_mode;
    logic [31:0] seg;
    logic [15:0] value;
    logic [3:0]  dp;
    logic        dashes;
    logic        led_hz;
    logic        led_a;
    logic        led_v;
  } mds_panel_type;

  typedef struct packed {
    logic          mrs_s1;
    logic          mrs_s2;
    logic          key_s1;
    logic          key_s2;
    mds_key_type   key_st;
    logic [31:0]   hold_cnt;
    mds_pos_type   pos;
    mds_pos_type   first_pos;
    logic [7:0]    mon_sel;
    logic [7:0]    pulse_src;
    logic [7:0]    volt_src;
    logic [31:0]   pre_cnt;
    logic [11:0]   sec_cnt;
    logic [11:0]   run_sec;
    logic [15:0]   energ_hrs;
    logic [15:0]   run_hrs;
    logic [31:0]   blink_cnt;
    logic          blink;
    logic          fault_d;
    logic [15:0]   fault_freq;
    mds_panel_type panel;
    logic [15:0]   pu_value;
    logic [15:0]   pulse_value;
    logic [15:0]   volt_value;
    logic [15:0]   rdata;
  } mds_state_type;
endpackage : mds_pkg

// ### src/mds_monitor_display_selector.sv
// Purpose: picks the quantity shown on the panel and the monitor outputs
// Assumes: drive values and flags come from logic on mclk
// Notes: hour counters and first monitor are volatile here
`timescale 1ns/1ps
module mds_monitor_display_selector
  import mds_pkg::*;
#(
  parameter int unsigned SEC_CYCLES   = CLK_HZ,
  parameter int unsigned HOLD_CYCLES  = CLK_HZ / MS_PER_S * HOLD_TIME_MS,
  parameter int unsigned BLINK_CYCLES = CLK_HZ / MS_PER_S * BLINK_TIME_MS
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // Register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output      logic [15:0]   reg_rdata,
  // Pins
  input  wire logic          output_stop_input,
  input  wire logic          confirm_key,
  // Drive state
  input  wire mds_drv_type   drv,
  input  wire mds_flag_type  flags,
  input  wire mds_term_type  terms,
  // Displays and monitor outputs
  output      mds_panel_type led_operation_panel,
  output      logic [15:0]   handheld_parameter_unit,
  output      logic [15:0]   pulse_train_monitor_terminal,
  output      logic [15:0]   analog_voltage_monitor_terminal
);

  if (SEC_CYCLES < 2 || HOLD_CYCLES < 1 || BLINK_CYCLES < 1) begin : g_chk
    $error("mds: timing counts too small");
  end

  mds_state_type s;
  mds_state_type n;
  logic          stopped;
  logic          sec_tick;
  logic [7:0]    sel;
  logic          is_pos2;
  logic          is_term;
  logic          is_acc;
  logic [15:0]   freq_show;
  logic [15:0]   sel_val;

  // Code 46 is left out, so the sequence value never reaches the panel
  function automatic logic mon_code_ok(input logic [7:0] c);
    case (c)
      CODE_CYCLE,
      CODE_LOAD,
      CODE_EXC,
      CODE_PPULSE,
      CODE_ENERG,
      CODE_ORIENT,
      CODE_RUNTIME,
      CODE_LFACTOR,
      CODE_PID_SP,
      CODE_PID_PV,
      CODE_PID_DEV,
      CODE_TERM,
      CODE_OPT_IN,
      CODE_OPT_OUT,
      CODE_SETFREQ: mon_code_ok = 1'b1;
      default: mon_code_ok = 1'b0;
    endcase
  endfunction : mon_code_ok

  // Deviation and terminal codes are absent on purpose
  function automatic logic out_src_ok(input logic [7:0] c);
    case (c)
      CODE_LOAD,
      CODE_EXC,
      CODE_LFACTOR,
      CODE_PID_SP,
      CODE_PID_PV,
      CODE_SEQ: out_src_ok = 1'b1;
      default: out_src_ok = 1'b0;
    endcase
  endfunction : out_src_ok

  // Orientation monitors read zero while orientation control is off
  function automatic logic [15:0] orient_gate(
    input logic        oen,
    input logic [15:0] v
  );
    if (oen) begin
      orient_gate = v;
    end else begin
      orient_gate = '0;
    end
  endfunction : orient_gate

  function automatic logic [15:0] mon_value(
    input logic [7:0]   c,
    input mds_drv_type  d,
    input logic         oen,
    input logic [15:0]  eh,
    input logic [15:0]  rh
  );
    case (c)
      CODE_PID_SP:  mon_value = d.pid_sp;
      CODE_PID_PV:  mon_value = d.pid_pv;
      CODE_PID_DEV: mon_value = d.pid_dev;
      CODE_LOAD:    mon_value = d.load_meter;
      CODE_EXC:     mon_value = d.exc_curr;
      CODE_LFACTOR: mon_value = d.load_factor;
      CODE_PPULSE:  mon_value = orient_gate(oen, d.pos_pulse);
      CODE_ORIENT:  mon_value = orient_gate(oen, d.orient_stat);
      CODE_ENERG:   mon_value = eh;
      CODE_RUNTIME: mon_value = rh;
      CODE_SEQ:     mon_value = d.seq_value;
      default:      mon_value = '0;
    endcase
  endfunction : mon_value

  // Digit k: a,b,f from upper bits, c,d,e from lower bits
  function automatic logic [31:0] build_seg(
    input logic [11:0] up,
    input logic [11:0] lo,
    input logic [3:0]  dp
  );
    logic [31:0] r;
    r = '0;
    for (int k = 0; k < 4; k++) begin
      r[k*8+0] = up[k*3+0];
      r[k*8+1] = up[k*3+1];
      r[k*8+5] = up[k*3+2];
      r[k*8+2] = lo[k*3+0];
      r[k*8+3] = lo[k*3+1];
      r[k*8+4] = lo[k*3+2];
      r[k*8+SEG_CENTRE] = 1'b1;
      r[k*8+SEG_DP] = dp[k];
    end
    build_seg = r;
  endfunction : build_seg

  // Option monitors show only the centre line without the card, the point stays lit
  function automatic logic [31:0] opt_seg(
    input logic        fit,
    input logic [23:0] bits,
    input logic [3:0]  dp
  );
    if (fit) begin
      opt_seg = build_seg(bits[11:0], bits[23:12], dp);
    end else begin
      opt_seg = build_seg(12'h000, 12'h000, dp);
    end
  endfunction : opt_seg

  function automatic mds_pos_type next_pos(input mds_pos_type p);
    case (p)
      POS_FREQ: next_pos = POS_CURR;
      POS_CURR: next_pos = POS_VOLT;
      POS_VOLT: next_pos = POS_FAULT;
      default:  next_pos = POS_FREQ;
    endcase
  endfunction : next_pos

  always_comb begin
    n = s;
    n.mrs_s1 = output_stop_input;
    n.mrs_s2 = s.mrs_s1;
    n.key_s1 = confirm_key;
    n.key_s2 = s.key_s1;
    stopped = !flags.running || s.mrs_s2;

    // Second prescaler feeding both hour counters
    sec_tick = (s.pre_cnt == 32'(SEC_CYCLES - 1));
    if (sec_tick) begin
      n.pre_cnt = '0;
      if (s.sec_cnt == 12'(HOUR_S - 1)) begin
        n.sec_cnt = '0;
        n.energ_hrs = s.energ_hrs + 16'h1;
      end else begin
        n.sec_cnt = s.sec_cnt + 12'h1;
      end
    end else begin
      n.pre_cnt = s.pre_cnt + 32'h1;
    end
    // Partial hour is lost at power-off since run_sec is not kept
    if (sec_tick && flags.running) begin
      if (s.run_sec == 12'(HOUR_S - 1)) begin
        n.run_sec = '0;
        n.run_hrs = s.run_hrs + 16'h1;
      end else begin
        n.run_sec = s.run_sec + 12'h1;
      end
    end

    if (s.blink_cnt == 32'(BLINK_CYCLES - 1)) begin
      n.blink_cnt = '0;
      n.blink = !s.blink;
    end else begin
      n.blink_cnt = s.blink_cnt + 32'h1;
    end

    n.fault_d = flags.fault;
    if (flags.fault && !s.fault_d) begin
      n.fault_freq = drv.freq;
    end

    // Short press steps, a 1 s hold stores the first monitor
    case (s.key_st)
      KEY_IDLE: begin
        n.hold_cnt = '0;
        if (s.key_s2) begin
          n.key_st = KEY_DOWN;
        end
      end
      KEY_DOWN: begin
        if (!s.key_s2) begin
          n.key_st = KEY_IDLE;
          n.pos = next_pos(s.pos);
        end else if (s.hold_cnt == 32'(HOLD_CYCLES - 1)) begin
          n.key_st = KEY_HELD;
          n.first_pos = s.pos;
        end else begin
          n.hold_cnt = s.hold_cnt + 32'h1;
        end
      end
      KEY_HELD: begin
        if (!s.key_s2) begin
          n.key_st = KEY_IDLE;
        end
      end
      default: n.key_st = KEY_IDLE;
    endcase

    // Refused writes keep the old value rather than clamping it
    if (reg_wr) begin
      case (reg_addr)
        REG_MON_SEL: begin
          if (reg_wdata[15:8] == '0 && mon_code_ok(reg_wdata[7:0])) begin
            n.mon_sel = reg_wdata[7:0];
          end
        end
        REG_PULSE_SRC: begin
          if (reg_wdata[15:8] == '0 && out_src_ok(reg_wdata[7:0])) begin
            n.pulse_src = reg_wdata[7:0];
          end
        end
        REG_VOLT_SRC: begin
          if (reg_wdata[15:8] == '0 && out_src_ok(reg_wdata[7:0])) begin
            n.volt_src = reg_wdata[7:0];
          end
        end
        default: ;
      endcase
    end

    // Read data stand one cycle and read zero otherwise
    n.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_MON_SEL:   n.rdata = {8'h00, s.mon_sel};
        REG_PULSE_SRC: n.rdata = {8'h00, s.pulse_src};
        REG_VOLT_SRC:  n.rdata = {8'h00, s.volt_src};
        REG_ENERG_HRS: n.rdata = s.energ_hrs;
        REG_RUN_HRS:   n.rdata = s.run_hrs;
        REG_STATUS:    n.rdata = {11'h000, stopped, s.first_pos, s.pos};
        default:       n.rdata = '0;
      endcase
    end

    n.pulse_value = mon_value(s.pulse_src, drv, flags.orient_en,
                              s.energ_hrs, s.run_hrs);
    n.volt_value = mon_value(s.volt_src, drv, flags.orient_en,
                             s.energ_hrs, s.run_hrs);

    sel = s.mon_sel;
    is_pos2 = (sel == CODE_LOAD) || (sel == CODE_EXC) ||
              (sel == CODE_LFACTOR);
    is_term = (sel == CODE_TERM) || (sel == CODE_OPT_IN) ||
              (sel == CODE_OPT_OUT);
    is_acc = (sel == CODE_ENERG) || (sel == CODE_RUNTIME);
    sel_val = mon_value(sel, drv, flags.orient_en, s.energ_hrs, s.run_hrs);
    // Capture lags a cycle, so the fault edge shows the live value
    if (flags.fault && !s.fault_d) begin
      freq_show = drv.freq;
    end else if (flags.fault) begin
      freq_show = s.fault_freq;
    end else if (sel == CODE_SETFREQ && stopped) begin
      freq_show = drv.set_freq;
    end else begin
      freq_show = drv.freq;
    end
    if (sel == CODE_CYCLE || sel == CODE_SETFREQ) begin
      n.pu_value = freq_show;
    end else begin
      n.pu_value = sel_val;
    end

    n.panel = '0;
    case (s.pos)
      POS_FREQ: begin
        n.panel.value = freq_show;
        if (sel == CODE_SETFREQ && stopped) begin
          n.panel.led_hz = s.blink;
        end else begin
          n.panel.led_hz = 1'b1;
        end
      end
      POS_CURR: begin
        if (is_pos2) begin
          n.panel.value = sel_val;
        end else begin
          n.panel.value = drv.curr;
          n.panel.led_a = 1'b1;
        end
      end
      POS_VOLT: begin
        if (sel == CODE_TERM) begin
          n.panel.seg_mode = 1'b1;
          n.panel.seg = build_seg(terms.in_terms, terms.out_terms,
                                  4'h0);
        end else if (sel == CODE_OPT_IN) begin
          n.panel.seg_mode = 1'b1;
          n.panel.seg = opt_seg(terms.opt_in_fit, terms.opt_in,
                                DP_OPT_IN);
        end else if (sel == CODE_OPT_OUT) begin
          n.panel.seg_mode = 1'b1;
          n.panel.seg = opt_seg(terms.opt_out_fit, terms.opt_out,
                                DP_OPT_OUT);
        end else if (is_acc) begin
          n.panel.value = sel_val / HOURS_DIV;
          n.panel.dp = DP_HOURS;
          // Tens of hours stay below 9999, so this guards rescaling
          n.panel.dashes = (n.panel.value > DASH_LIMIT);
        end else if (sel != CODE_CYCLE && sel != CODE_SETFREQ &&
                     !is_pos2 && !is_term) begin
          n.panel.value = sel_val;
        end else begin
          n.panel.value = drv.volt;
          n.panel.led_v = 1'b1;
        end
      end
      POS_FAULT: n.panel.value = drv.fault_code;
      default: n.panel.value = '0;
    endcase
    if (flags.tuning) begin
      n.panel = '0;
      n.panel.value = drv.tune_stat;
    end
  end

  // Hours and the first monitor are volatile and restart at reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.key_st <= KEY_IDLE;
      s.pos <= POS_FREQ;
      s.first_pos <= POS_FREQ;
      s.mon_sel <= MON_SEL_RST;
      s.pulse_src <= OUT_SRC_RST;
      s.volt_src <= OUT_SRC_RST;
    end else begin
      s <= n;
    end
  end

  // Outputs are state fields, so each leaves the block from a flop
  assign reg_rdata = s.rdata;
  assign led_operation_panel = s.panel;
  assign handheld_parameter_unit = s.pu_value;
  assign pulse_train_monitor_terminal = s.pulse_value;
  assign analog_voltage_monitor_terminal = s.volt_value;

endmodule : mds_monitor_display_selector

// ### verif/mds_checker_props.sv
// Purpose: port-level checks for the monitor display selector
// Assumes: bound to the top module, sees its ports only
// Notes: shadows of the select registers follow accepted writes
`timescale 1ns/1ps
module mds_checker
  import mds_pkg::*;
(
  // Clock and reset
  input wire logic          mclk,
  input wire logic          rst_n,
  // Register port
  input wire logic [3:0]    reg_addr,
  input wire logic [15:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [15:0]   reg_rdata,
  // Pins and drive state
  input wire logic          output_stop_input,
  input wire logic          confirm_key,
  input wire mds_drv_type   drv,
  input wire mds_flag_type  flags,
  input wire mds_term_type  terms,
  // Outputs
  input wire mds_panel_type led_operation_panel,
  input wire logic [15:0]   handheld_parameter_unit,
  input wire logic [15:0]   pulse_train_monitor_terminal,
  input wire logic [15:0]   analog_voltage_monitor_terminal
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0]  mon;
  logic [7:0]  psrc;
  logic [31:0] sg;
  mds_panel_type p;
  assign p  = led_operation_panel;
  assign sg = led_operation_panel.seg;
  // Segments lit under a mask, summed over the four digits
  function automatic int cnt(logic [31:0] s, logic [7:0] m);
    int n;
    n = 0;
    for (int k = 0; k < 4; k++) n += $countones(s[k*8+:8] & m);
    return n;
  endfunction : cnt
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mon  <= MON_SEL_RST;
      psrc <= OUT_SRC_RST;
    end else if (reg_wr && reg_wdata[15:8] == 8'h00) begin
      if (reg_addr == REG_MON_SEL && reg_wdata[7:0] inside {8'h00, 8'h11,
          8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18, [8'h34:8'h39], 8'h64})
        mon <= reg_wdata[7:0];
      if (reg_addr == REG_PULSE_SRC && reg_wdata[7:0] inside {8'h11, 8'h12,
          8'h18, 8'h34, 8'h35, 8'h46})
        psrc <= reg_wdata[7:0];
    end
  end
  chk_centre_lit: assert property (p.seg_mode |->
    sg[6] && sg[14] && sg[22] && sg[30]) else $error("centre line dark");
  chk_upper_inputs: assert property (
    p.seg_mode && $past(mon) == CODE_TERM |->
    cnt(sg, 8'h23) == $countones($past(terms.in_terms)))
    else $error("upper segments differ from inputs");
  chk_lower_outputs: assert property (
    p.seg_mode && $past(mon) == CODE_TERM |->
    cnt(sg, 8'h1c) == $countones($past(terms.out_terms)))
    else $error("lower segments differ from outputs");
  chk_absent_dark: assert property (
    p.seg_mode && $past(mon) == CODE_OPT_IN && !$past(terms.opt_in_fit)
    |-> cnt(sg, 8'h3f) == 0) else $error("segments lit without card");
  chk_opt_in_point: assert property (
    p.seg_mode && $past(mon) == CODE_OPT_IN |-> sg[7] && !sg[15])
    else $error("wrong point for option inputs");
  chk_opt_out_point: assert property (
    p.seg_mode && $past(mon) == CODE_OPT_OUT |-> sg[15] && !sg[7])
    else $error("wrong point for option outputs");
  chk_tuning_wins: assert property (flags.tuning |=>
    p.value == $past(drv.tune_stat) && !p.seg_mode)
    else $error("tuning status not shown");
  chk_units_alone: assert property (
    $onehot0({p.led_hz, p.led_a, p.led_v}) &&
    !(p.seg_mode && (p.led_hz || p.led_a || p.led_v)))
    else $error("unit lamps wrong");
  chk_stop_setfreq: assert property (
    mon == CODE_SETFREQ && !flags.running && !flags.fault && !flags.tuning
    |=> p.led_hz |-> p.value == $past(drv.set_freq))
    else $error("stopped frequency not the set one");
  chk_seq_pulse: assert property (rst_n && psrc == CODE_SEQ |=>
    pulse_train_monitor_terminal == $past(drv.seq_value))
    else $error("sequence value not on pulse output");
  chk_fault_caught: assert property (
    flags.fault && !$past(flags.fault) && !flags.tuning |=>
    p.led_hz |-> p.value == $past(drv.freq))
    else $error("frequency not caught at fault");
  cov_segments: cover property (p.seg_mode);
  cov_tuning: cover property (flags.tuning);
  cov_hours: cover property (p.dp == DP_HOURS);
endmodule : mds_checker

// ### verif/mds_panel_model.sv
// Purpose: operator and panel stand-in for the display selector
// Assumes: key press lengths in cycles come from the bench
// Notes: counts Hz lamp changes so blinking can be judged
`timescale 1ns/1ps
module mds_panel_model
  import mds_pkg::*;
(
  // Bench side
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          press_go,
  input  wire logic [7:0]    press_len,
  // Panel side
  input  wire mds_panel_type panel,
  output      logic          confirm_key,
  output      logic [7:0]    hz_flips
);
  logic [7:0] left;
  logic       hz_d;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      left     <= 8'h00;
      hz_d     <= 1'b0;
      hz_flips <= 8'h00;
    end else begin
      left     <= press_go ? press_len : left - {7'h00, left != 8'h00};
      hz_d     <= panel.led_hz;
      hz_flips <= hz_flips + {7'h00, hz_d != panel.led_hz};
    end
  end
  // A hold longer than the key timer makes the shown monitor the first
  assign confirm_key = left != 8'h00;
endmodule : mds_panel_model

// ### verif/test_monitor_display_selector.sv
// Purpose: directed run of the monitor display selector
// Assumes: 4-cycle second, 8-cycle hold, 3-cycle blink
// Notes: the 65535 hour wrap is far beyond any run length
`timescale 1ns/1ps
module test_monitor_display_selector
  import mds_pkg::*;
;
  logic          mclk, rst_n, reg_wr, reg_rd, output_stop_input, pgo, key;
  logic [3:0]    reg_addr;
  logic [15:0]   reg_wdata, reg_rdata, hh_out, pulse_out, volt_out, q;
  logic [7:0]    plen, flips, f0;
  logic [2:0]    units;
  mds_drv_type   drv;
  mds_flag_type  flags;
  mds_term_type  terms;
  mds_panel_type pan;
  int            n_fail, tests_run, cyc;
  logic [15:0]   bad_v [3] = '{16'h0046, 16'h0099, 16'h0134};
  logic [15:0]   cyc_v [4] = '{16'h3333, 16'h4444, 16'h5555, 16'h1111};
  logic [2:0]    cyc_u [4] = '{3'b010, 3'b001, 3'b000, 3'b100};
  assign units = {pan.led_hz, pan.led_a, pan.led_v};
  mds_monitor_display_selector #(.SEC_CYCLES(4), .HOLD_CYCLES(8),
    .BLINK_CYCLES(3)) mds_monitor_display_selector_i (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .output_stop_input(output_stop_input),
    .confirm_key(key), .drv(drv), .flags(flags), .terms(terms),
    .led_operation_panel(pan), .handheld_parameter_unit(hh_out),
    .pulse_train_monitor_terminal(pulse_out),
    .analog_voltage_monitor_terminal(volt_out));
  mds_panel_model mds_panel_model_i (.mclk(mclk), .rst_n(rst_n),
    .press_go(pgo), .press_len(plen), .panel(pan), .confirm_key(key),
    .hz_flips(flips));
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_n
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe is taken
  task rd(input logic [3:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  task sel(input logic [15:0] c);
    wr(REG_MON_SEL, c);
    wait_n(3);
  endtask : sel
  task row(input logic [15:0] c, input logic [15:0] e, input logic [2:0] u);
    sel(c);
    chk(pan.value, e);
    chk(units, u);
  endtask : row
  task press(input logic [7:0] n);
    @(posedge mclk);
    pgo <= 1'b1;
    plen <= n;
    @(posedge mclk);
    pgo <= 1'b0;
    wait_n(n + 8);
  endtask : press
  task report_and_stop;
    $display("n_fail=%0d tests_run=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // Longest path is the hour counting, some 30k cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, pgo, plen} = '0;
    {output_stop_input, rst_n, n_fail, tests_run, cyc} = '0;
    drv = {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h0101,
      16'h0202, 16'h0303, 16'h0404, 16'h0505, 16'h0606, 16'h0707,
      16'h0808, 16'h0909, 16'h0a0a};
    flags = '0;
    terms = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    wait_n(2);
    chk(pan.value, 16'h1111);
    chk(units, 3'b100);
    rd(REG_PULSE_SRC);
    chk(q, 16'h0046);
    chk(pulse_out, 16'h0909);
    for (int i = 0; i < 3; i++) begin
      wr(REG_MON_SEL, bad_v[i]);
      rd(REG_MON_SEL);
      chk(q, 16'h0000);
    end
    wr(REG_ENERG_HRS, 16'h00ff);
    rd(4'hf);
    chk(q, 16'h0000);
    wr(REG_PULSE_SRC, 16'h0036);
    wr(REG_PULSE_SRC, 16'h0037);
    rd(REG_PULSE_SRC);
    chk(q, 16'h0046);
    wr(REG_PULSE_SRC, 16'h0034);
    wr(REG_VOLT_SRC, 16'h0035);
    wr(REG_VOLT_SRC, 16'h0038);
    rd(REG_VOLT_SRC);
    chk(q, 16'h0035);
    chk(pulse_out, 16'h0101);
    chk(volt_out, 16'h0202);
    for (int i = 0; i < 4; i++) begin
      press(3);
      chk(pan.value, cyc_v[i]);
      chk(units, cyc_u[i]);
    end
    press(3);
    press(3);
    row(16'h0034, 16'h0101, 3'b000);
    chk(hh_out, 16'h0101);
    row(16'h0035, 16'h0202, 3'b000);
    row(16'h0036, 16'h0303, 3'b000);
    row(16'h0011, 16'h4444, 3'b001);
    row(16'h0013, 16'h0000, 3'b000);
    row(16'h0016, 16'h0000, 3'b000);
    flags.orient_en <= 1'b1;
    row(16'h0016, 16'h0808, 3'b000);
    repeat (3) press(3);
    row(16'h0011, 16'h0404, 3'b000);
    row(16'h0012, 16'h0505, 3'b000);
    row(16'h0018, 16'h0606, 3'b000);
    row(16'h0034, 16'h3333, 3'b010);
    press(3);
    terms.in_terms <= 12'h005;
    terms.out_terms <= 12'h0c0;
    sel(16'h0037);
    chk(pan.seg_mode, 1'b1);
    chk($countones(pan.seg), 8);
    sel(16'h0038);
    chk($countones(pan.seg), 5);
    chk(pan.seg[7], 1'b1);
    terms.opt_out_fit <= 1'b1;
    terms.opt_out <= 24'h001003;
    sel(16'h0039);
    chk($countones(pan.seg), 8);
    chk(pan.seg[15], 1'b1);
    sel(16'h0014);
    wait_n(15000);
    chk(pan.dp, DP_HOURS);
    chk(pan.value, 16'h0000);
    chk(pan.dashes, 1'b0);
    rd(REG_ENERG_HRS);
    chk(q, 16'h0001);
    rd(REG_RUN_HRS);
    chk(q, 16'h0000);
    flags.running <= 1'b1;
    wait_n(7300);
    rd(REG_RUN_HRS);
    chk(q, 16'h0000);
    wait_n(7300);
    rd(REG_RUN_HRS);
    chk(q, 16'h0001);
    rd(REG_ENERG_HRS);
    chk(q, 16'h0002);
    sel(16'h0017);
    chk(pan.dp, DP_HOURS);
    press(3);
    press(3);
    sel(16'h0064);
    f0 = flips;
    wait_n(20);
    chk(flips - f0, 8'h00);
    chk(pan.value, 16'h1111);
    output_stop_input <= 1'b1;
    wait_n(6);
    chk(pan.value, 16'h2222);
    flags.running <= 1'b0;
    output_stop_input <= 1'b0;
    wait_n(6);
    f0 = flips;
    wait_n(30);
    chk(flips - f0 >= 8'h08, 1'b1);
    chk(pan.value, 16'h2222);
    chk(hh_out, 16'h2222);
    sel(16'h0000);
    flags.fault <= 1'b1;
    wait_n(3);
    drv.freq <= 16'h7777;
    wait_n(3);
    chk(pan.value, 16'h1111);
    chk(hh_out, 16'h1111);
    flags.fault <= 1'b0;
    flags.tuning <= 1'b1;
    wait_n(3);
    chk(pan.value, 16'h0a0a);
    chk(units, 3'b000);
    flags.tuning <= 1'b0;
    press(3);
    press(12);
    chk(pan.value, 16'h3333);
    rd(REG_STATUS);
    chk(q[4:0], 5'h15);
    @(posedge mclk);
    rst_n <= 1'b0;
    wait_n(3);
    rst_n <= 1'b1;
    wait_n(3);
    chk(pan.value, 16'h7777);
    report_and_stop();
  end
endmodule : test_monitor_display_selector

bind mds_monitor_display_selector mds_checker mds_checker_i (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .output_stop_input(output_stop_input), .confirm_key(confirm_key),
  .drv(drv), .flags(flags), .terms(terms),
  .led_operation_panel(led_operation_panel),
  .handheld_parameter_unit(handheld_parameter_unit),
  .pulse_train_monitor_terminal(pulse_train_monitor_terminal),
  .analog_voltage_monitor_terminal(analog_voltage_monitor_terminal));
